// ---- dv/cubic_resampler_chk.sv ----
// Port-level concurrent checks for the cubic resampler.
`timescale 1ns/1ps
`default_nettype none
module cubic_resampler_chk (
  input wire logic core_clk_in, // System clock.
  input wire logic reset_in, // Synchronous reset.
  input wire logic start_in, // Block start.
  input wire cubic_resamp_pkg::rate_cfg_t cfg_in, // Rates.
  input wire cubic_resamp_pkg::pcm_t sample_in, // Input sample.
  input wire logic sample_valid_in, // Input offered.
  input wire logic sample_ready_out, // Input taken.
  input wire cubic_resamp_pkg::pcm_t out_sample_out, // Output sample.
  input wire logic out_valid_out, // Output offered.
  input wire logic out_ready_in, // Output taken.
  input wire logic busy_out, // Block running.
  input wire logic done_out // Last output queued.
);
  import cubic_resamp_pkg::*;
  logic [IDX_W-1:0] take_cnt;
  logic [IDX_W-1:0] blk_len;
  logic take;
  logic last_take;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // Takes are counted per block so the checks know where the input stream ends.
  assign take = sample_valid_in & sample_ready_out;
  assign last_take = take && (take_cnt == blk_len - 5'h01);
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || (start_in && !busy_out))
      take_cnt <= 5'h00;
    else if (take)
      take_cnt <= take_cnt + 5'h01;
  end
  // Block length is latched with an accepted start, as the design does with its rates.
  always_ff @(posedge core_clk_in)
  begin
    if (start_in && !busy_out)
      blk_len <= PAST_LEN + ((cfg_in.in_rate == RATE_12K8) ? BLOCK_LEN_12K8 : BLOCK_LEN_16K);
  end
  reset_clear_a: assert property ($fell(reset_in) |-> !busy_out && !sample_ready_out && !out_valid_out && !done_out)
    else $error("outputs not cleared by reset");
  start_ready_a: assert property (start_in && !busy_out |=> sample_ready_out && busy_out)
    else $error("start did not open the input stream");
  idle_quiet_a: assert property (!busy_out |-> !sample_ready_out && !out_valid_out)
    else $error("stream active while idle");
  take_bound_a: assert property (sample_ready_out |-> take_cnt < blk_len)
    else $error("more samples taken than the block holds");
  ready_drop_a: assert property (last_take |=> !sample_ready_out)
    else $error("input still open after the last sample");
  first_out_a: assert property (last_take |=> !out_valid_out ##1 out_valid_out)
    else $error("first output not two cycles after last input");
  out_hold_a: assert property (out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_sample_out))
    else $error("output changed before it was taken");
  done_pulse_a: assert property (done_out |-> busy_out && !sample_ready_out ##1 !done_out)
    else $error("done is not a single pulse at block end");
  busy_end_a: assert property ($fell(busy_out) |-> !out_valid_out)
    else $error("busy dropped with outputs still queued");
endmodule // cubic_resampler_chk
bind cubic_resampler cubic_resampler_chk chk_u (.core_clk_in, .reset_in, .start_in, .cfg_in, .sample_in,
  .sample_valid_in, .sample_ready_out, .out_sample_out, .out_valid_out, .out_ready_in, .busy_out, .done_out);
`default_nettype wire

// ---- dv/cubic_resampler_tb.sv ----
// Self-checking testbench for the cubic resampler.
`timescale 1ns/1ps
`default_nettype none
module cubic_resampler_tb;
  import cubic_resamp_pkg::*;
  typedef struct {int v; int tol;} note_t;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic start_in = 1'b0;
  rate_cfg_t cfg_in = '0;
  pcm_t sample_in;
  logic sample_valid_in;
  logic sample_ready_out;
  pcm_t out_sample_out;
  logic out_valid_out;
  logic out_ready_in;
  logic busy_out;
  logic done_out;
  integer seed = 32'h2963;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int done_cnt = 0;
  int d;
  note_t nt;
  note_t exp_q[$];
  // Free-running 250 MHz clock.
  initial
    forever #2 core_clk_in = ~core_clk_in;
  cubic_resampler dut_u (.core_clk_in, .reset_in, .start_in, .cfg_in, .sample_in, .sample_valid_in,
    .sample_ready_out, .out_sample_out, .out_valid_out, .out_ready_in, .busy_out, .done_out);
  resamp_partner_model src_u (.core_clk_in, .sample_ready_in(sample_ready_out), .sample_out(sample_in),
    .sample_valid_out(sample_valid_in), .out_ready_out(out_ready_in));
  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  function automatic int step_of(input in_rate_t ir, input out_rate_t orr);
    if (ir == RATE_12K8)
      return int'(orr == OUT_32K ? STEP_12K8_TO_32K : orr == OUT_16K ? STEP_12K8_TO_16K : STEP_12K8_TO_8K);
    return int'(orr == OUT_32K ? STEP_16K_TO_32K : orr == OUT_16K ? STEP_16K_TO_16K : STEP_16K_TO_8K);
  endfunction
  // One block: a ramp (or a constant when kk is zero), with a refused start while busy.
  task automatic run_block(input in_rate_t ir, input out_rate_t orr, input int kk, input int st);
    int base;
    int len;
    int s;
    int d0;
    base = $random(seed) % 8000;
    len = int'(PAST_LEN) + int'(ir == RATE_12K8 ? BLOCK_LEN_12K8 : BLOCK_LEN_16K);
    s = step_of(ir, orr);
    d0 = done_cnt;
    src_u.stall = st;
    // A ramp is exact up to where the repeated tail bends the last cubics.
    for (int p = 20; p < (len - 1) * 10; p += s)
      exp_q.push_back('{base + kk * p, (kk == 0 || p < (len - 5) * 10) ? 2 : 99999});
    fork
      src_u.send_block(base, kk * 10, len);
      begin
        start_in = 1'b1;
        cfg_in = '{ir, orr};
        @(posedge core_clk_in) #1 start_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        #1 start_in = 1'b1;
        cfg_in = '{(ir == RATE_12K8) ? RATE_16K : RATE_12K8, OUT_8K};
        @(posedge core_clk_in) #1 start_in = 1'b0;
      end
    join
    while (busy_out !== 1'b0)
      @(posedge core_clk_in);
    #1;
    chk(32'(done_cnt - d0), 32'h1);
    chk(32'(exp_q.size()), 32'h0);
    $display("block in %0d out %0d step %0d finished", ir, orr, s);
  endtask
  // Each accepted output is matched against the oldest note.
  always @(posedge core_clk_in)
  begin
    if (out_valid_out === 1'b1 && out_ready_in === 1'b1)
    begin
      nt = '{99999, 0};
      if (exp_q.size() > 0)
        nt = exp_q.pop_front();
      d = int'(out_sample_out) - nt.v;
      checks++;
      if ((^out_sample_out) === 1'bx || d > nt.tol || -d > nt.tol)
      begin
        failures++;
        $display("[ERR] t=%0t got=%0h exp=%0h", $time, out_sample_out, nt.v[15:0]);
      end
    end
  end
  // Done pulses are counted so each block can be shown to end exactly once.
  always @(posedge core_clk_in)
  begin
    if (done_out === 1'b1)
      done_cnt++;
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end
  // Main sequence: reset, six rate pairs on ramps, then constants under heavy backpressure.
  initial
  begin
    repeat (3) @(posedge core_clk_in);
    #1 reset_in = 1'b0;
    chk({29'h0, busy_out, sample_ready_out, out_valid_out}, 32'h0);
    for (int r = 0; r < 6; r++)
      run_block(in_rate_t'(r % 2), out_rate_t'(r / 2), $random(seed) % 40, r);
    run_block(RATE_12K8, OUT_32K, 0, 14);
    run_block(RATE_16K, OUT_8K, 0, 14);
    end_sim();
  end
endmodule // cubic_resampler_tb
`default_nettype wire

// ---- dv/resamp_partner_model.sv ----
// Model of the upstream resampling memory and the downstream cross-fade sink.
`timescale 1ns/1ps
`default_nettype none
module resamp_partner_model (
  input wire logic core_clk_in, // System clock.
  input wire logic sample_ready_in, // Resampler takes a sample.
  output cubic_resamp_pkg::pcm_t sample_out, // Memory sample.
  output logic sample_valid_out, // Memory sample offered.
  output logic out_ready_out // Sink takes an output.
);
  import cubic_resamp_pkg::*;
  integer seed = 32'h2963;
  int stall = 0;
  // The sink refuses at random; a high stall keeps the output buffer full.
  initial
  begin
    sample_out = '0;
    sample_valid_out = 1'b0;
    out_ready_out = 1'b1;
    forever
    begin
      @(posedge core_clk_in);
      #1 out_ready_out = ($random(seed) & 15) >= stall;
    end
  end
  // Sends past memory and new samples, each held until taken.
  task automatic send_block(input int base, input int k, input int len);
    pcm_t v;
    sample_valid_out = 1'b1;
    for (int j = 0; j < len; j++)
    begin
      v = pcm_t'(base + k * ((j < len - 2) ? j : len - 3));
      sample_out = v;
      @(posedge core_clk_in);
      while (sample_ready_in !== 1'b1)
        @(posedge core_clk_in);
      #1;
    end
    sample_valid_out = 1'b0;
    sample_out = ~v;
  endtask
endmodule // resamp_partner_model
`default_nettype wire

// ---- src/cubic_resamp_pkg.sv ----
// Constants, types and table builder for the cubic interpolation resampler.
// How it works
// - Input runs at 12.8 or 16 kHz and is interpolated to the output rate.
// - Buffer holds 16 or 20 new samples plus 2 earlier samples.
// - Each cubic is fitted on four consecutive samples at -1, 0, 1 and 2.
// - Coefficients: quadratic, cubic, linear and constant terms by the fixed formulas.
// - Each interval is evaluated on its own, preceding and following cubic.
// - Fraction x runs 0 to 1 from the start of the output's interval.
// - With three cubics present the output is their equal-weight mean.
// - Stored tables hold powers of x, x-1, x+1 divided by 3.
// - For 12.8 to 32 kHz the fractions are 0.2, 0.4, 0.6, 0.8 and 0.
// - Second-to-last interval uses only the central span of the final cubic.
// - Final interval uses only the [1,2] span of that final cubic.
// - No output past the last input sample when decimating.
package cubic_resamp_pkg;
  localparam int SAMPLE_W = 16;
  localparam int COEF_W = 24;
  localparam int TAB_W = 20;
  localparam int ACC_W = 48;
  localparam int FRAC_Q = 15;
  localparam int IDX_W = 5;
  localparam int FIFO_DEPTH = 8;
  // Fractions are counted in tenths of an input interval.
  localparam logic [4:0] FRAC_DEN = 5'h0A;
  localparam int TAB_LEN = 30;
  localparam logic [IDX_W-1:0] PAST_LEN = 5'h02;
  localparam logic [IDX_W-1:0] BLOCK_LEN_12K8 = 5'h10;
  localparam logic [IDX_W-1:0] BLOCK_LEN_16K = 5'h14;
  localparam int BUF_MAX = 22;
  localparam logic signed [TAB_W-1:0] ONE_THIRD_Q15 = 20'sh02AAB;
  // Phase steps in tenths of an input interval per output sample.
  localparam logic [4:0] STEP_12K8_TO_32K = 5'h04;
  localparam logic [4:0] STEP_12K8_TO_16K = 5'h08;
  localparam logic [4:0] STEP_12K8_TO_8K = 5'h10;
  localparam logic [4:0] STEP_16K_TO_32K = 5'h05;
  localparam logic [4:0] STEP_16K_TO_16K = 5'h0A;
  localparam logic [4:0] STEP_16K_TO_8K = 5'h14;

  typedef enum logic {RATE_12K8, RATE_16K} in_rate_t;
  typedef enum logic [1:0] {OUT_8K, OUT_16K, OUT_32K} out_rate_t;
  typedef logic signed [SAMPLE_W-1:0] pcm_t;
  typedef struct packed {
    in_rate_t in_rate;
    out_rate_t out_rate;
  } rate_cfg_t;
  typedef struct packed {
    logic signed [COEF_W-1:0] a;
    logic signed [COEF_W-1:0] b;
    logic signed [COEF_W-1:0] c;
    logic signed [COEF_W-1:0] d;
  } cubic_t;
  typedef logic [TAB_LEN-1:0][2:0][TAB_W-1:0] pow_tab_t;

  // Entry t holds u, u^2, u^3 over 3 in Q15, where u = (t-10)/10.
  function automatic pow_tab_t build_pow_tab();
    pow_tab_t tab;
    longint num;
    longint den;
    longint k;
    tab = '0;
    for (int t = 0; t < TAB_LEN; t++)
    begin
      k = t - 10;
      num = k * 32768;
      den = 30;
      for (int p = 0; p < 3; p++)
      begin
        if (num >= 0)
          tab[t][p] = TAB_W'((num + den / 2) / den);
        else
          tab[t][p] = TAB_W'(-((-num + den / 2) / den));
        num = num * k;
        den = den * 10;
      end
    end
    return tab;
  endfunction

  localparam pow_tab_t POW_TAB = build_pow_tab();
endpackage

// ---- src/cubic_resampler.sv ----
// Low-delay cubic interpolation resampler for coding-mode transitions.
`timescale 1ns/1ps
`default_nettype none
module cubic_resampler (
  input wire logic core_clk_in, // System clock, 250 MHz.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic start_in, // Pulse: begin a block.
  input wire cubic_resamp_pkg::rate_cfg_t cfg_in, // Rates, taken with start.
  input wire cubic_resamp_pkg::pcm_t sample_in, // Input sample.
  input wire logic sample_valid_in, // Input sample offered.
  output logic sample_ready_out, // Input sample taken.
  output cubic_resamp_pkg::pcm_t out_sample_out, // Output sample.
  output logic out_valid_out, // Output sample offered.
  input wire logic out_ready_in, // Output sample taken.
  output logic busy_out, // Block in progress.
  output logic done_out // Pulse: last output queued.
);
  import cubic_resamp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_DRAIN} state_t;

  state_t state;
  rate_cfg_t cfg;
  pcm_t buf_mem [BUF_MAX];
  logic [IDX_W-1:0] load_cnt;
  logic [IDX_W-1:0] buf_len;
  logic [IDX_W-1:0] interval;
  logic [4:0] frac;
  logic [IDX_W-1:0] next_interval;
  logic [4:0] next_frac;
  logic take;
  logic push;
  logic last_push;
  logic fifo_ready;
  cubic_t cub_prev;
  cubic_t cub_cen;
  cubic_t cub_next;
  logic signed [ACC_W-1:0] acc;
  pcm_t result;

  // Buffer length: two memory samples plus the block for the chosen rate.
  function automatic logic [IDX_W-1:0] len_of(input in_rate_t r);
    if (r == RATE_12K8)
      return PAST_LEN + BLOCK_LEN_12K8;
    return PAST_LEN + BLOCK_LEN_16K;
  endfunction

  // Phase step per output sample, in tenths of an input interval.
  function automatic logic [4:0] step_of(input rate_cfg_t c);
    logic [4:0] s;
    s = STEP_16K_TO_16K;
    if (c.in_rate == RATE_12K8)
    begin
      unique case (c.out_rate)
        OUT_32K: s = STEP_12K8_TO_32K;
        OUT_16K: s = STEP_12K8_TO_16K;
        OUT_8K: s = STEP_12K8_TO_8K;
        default: s = STEP_12K8_TO_16K;
      endcase
    end
    else
    begin
      unique case (c.out_rate)
        OUT_32K: s = STEP_16K_TO_32K;
        OUT_16K: s = STEP_16K_TO_16K;
        OUT_8K: s = STEP_16K_TO_8K;
        default: s = STEP_16K_TO_16K;
      endcase
    end
    return s;
  endfunction

  // Reads at index BUF_MAX or beyond return zero so stray indices stay harmless.
  function automatic logic signed [COEF_W-1:0] rd(input logic [IDX_W:0] idx);
    if (idx < (IDX_W+1)'(BUF_MAX))
      return COEF_W'(buf_mem[idx[IDX_W-1:0]]);
    return '0;
  endfunction

  // Fit a cubic whose central interval starts at sample j.
  function automatic cubic_t cubic_fit(input logic [IDX_W-1:0] j);
    cubic_t q;
    logic signed [COEF_W-1:0] vm1;
    logic signed [COEF_W-1:0] v0;
    logic signed [COEF_W-1:0] v1;
    logic signed [COEF_W-1:0] v2;
    vm1 = rd({1'b0, j} - 1'b1);
    v0 = rd({1'b0, j});
    v1 = rd({1'b0, j} + 1'b1);
    v2 = rd({1'b0, j} + 2'h2);
    // Halving truncates toward zero; a half-step bias is accepted.
    q.b = (vm1 + v1) / 2 - v0;
    q.a = (vm1 + v2 - v0 - v1 - 4 * q.b) / 6;
    q.c = v1 - v0 - q.a - q.b;
    q.d = v0;
    return q;
  endfunction

  // Evaluate one cubic at table entry t; the 1/3 weight is in the table.
  function automatic logic signed [ACC_W-1:0] cubic_eval(input cubic_t q, input logic [4:0] t);
    logic signed [ACC_W-1:0] s;
    s = ACC_W'(q.a * $signed(POW_TAB[t][2]));
    s = s + ACC_W'(q.b * $signed(POW_TAB[t][1]));
    s = s + ACC_W'(q.c * $signed(POW_TAB[t][0]));
    s = s + ACC_W'(q.d * ONE_THIRD_Q15);
    return s;
  endfunction

  // Drop the Q15 fraction with rounding and clip to the sample range.
  function automatic pcm_t sat_pcm(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] r;
    r = (v + (ACC_W'(1) <<< (FRAC_Q - 1))) >>> FRAC_Q;
    if (r > ACC_W'(32767))
      return 16'h7FFF;
    if (r < -ACC_W'(32768))
      return 16'h8000;
    return r[SAMPLE_W-1:0];
  endfunction

  assign take = sample_ready_out && sample_valid_in;
  assign push = (state == ST_RUN) && fifo_ready;

  // Interval i starts at sample i; interval PAST_LEN starts at the first new sample.
  assign cub_prev = cubic_fit(interval - 1'b1);
  assign cub_cen = cubic_fit(interval);
  assign cub_next = cubic_fit(interval + 1'b1);

  // Blend the cubics; the last two intervals fall back to a single curve.
  // A single curve is scaled by 3 to undo the table's built-in weight.
  always_comb
  begin
    acc = '0;
    if (interval == buf_len - 2'h2)
      acc = 3 * cubic_eval(cub_prev, frac + 5'h14);
    else if (interval == buf_len - 2'h3)
      acc = 3 * cubic_eval(cub_cen, frac + FRAC_DEN);
    else
    begin
      // Table entry frac+20 is x+1, frac+10 is x and frac is x-1.
      acc = cubic_eval(cub_prev, frac + 5'h14);
      acc = acc + cubic_eval(cub_cen, frac + FRAC_DEN);
      acc = acc + cubic_eval(cub_next, frac);
    end
    result = sat_pcm(acc);
  end

  // Phase stepper: the fraction wraps in tenths and carries into the interval.
  always_comb
  begin
    logic [5:0] sum;
    sum = 6'(frac) + 6'(step_of(cfg));
    next_interval = interval;
    next_frac = sum[4:0];
    if (sum >= 6'h14)
    begin
      next_interval = interval + 2'h2;
      next_frac = 5'(sum - 6'h14);
    end
    else if (sum >= 6'(FRAC_DEN))
    begin
      next_interval = interval + 1'b1;
      next_frac = 5'(sum - 6'(FRAC_DEN));
    end
    // Stop once the next position reaches or passes the last input sample.
    last_push = (next_interval > buf_len - 2'h2);
  end

  // Block sequencing.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      state <= ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE:
          if (start_in && !busy_out)
            state <= ST_LOAD;
        ST_LOAD:
          if (take && load_cnt == buf_len - 1'b1)
            state <= ST_RUN;
        ST_RUN:
          if (push && last_push)
            state <= ST_DRAIN;
        ST_DRAIN:
          if (!out_valid_out)
            state <= ST_IDLE;
      endcase
    end
  end

  // Rates are latched at start so a change mid-block cannot tear a block.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      cfg <= '{in_rate: RATE_12K8, out_rate: OUT_32K};
      buf_len <= PAST_LEN + BLOCK_LEN_12K8;
    end
    else if (state == ST_IDLE && start_in && !busy_out)
    begin
      cfg <= cfg_in;
      buf_len <= len_of(cfg_in.in_rate);
    end
  end

  // Input ready is held only while the buffer still has room.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      sample_ready_out <= 1'b0;
    else if (state == ST_IDLE && start_in && !busy_out)
      sample_ready_out <= 1'b1;
    else if (take && load_cnt == buf_len - 1'b1)
      sample_ready_out <= 1'b0;
  end

  // Load count; the two earliest samples are the cubic memory.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      load_cnt <= '0;
    else if (state == ST_IDLE)
      load_cnt <= '0;
    else if (take)
      load_cnt <= load_cnt + 1'b1;
  end

  // Sample store; no reset is needed as every used word is written first.
  always_ff @(posedge core_clk_in)
  begin
    if (take)
      buf_mem[load_cnt] <= sample_in;
  end

  // Phase counter starts at x = 0 of the first new sample's interval.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      interval <= PAST_LEN;
      frac <= '0;
    end
    else if (state == ST_LOAD)
    begin
      interval <= PAST_LEN;
      frac <= '0;
    end
    else if (push)
    begin
      interval <= next_interval;
      frac <= next_frac;
    end
  end

  // Status flags.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      busy_out <= (state != ST_IDLE) || (start_in && !busy_out);
      done_out <= push && last_push;
    end
  end

  // Output queue absorbs stalls from the cross-fade side.
  pcm_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .wr_data_in(result),
    .wr_valid_in(state == ST_RUN),
    .wr_ready_out(fifo_ready),
    .rd_data_out(out_sample_out),
    .rd_valid_out(out_valid_out),
    .rd_ready_in(out_ready_in)
  );
endmodule // cubic_resampler
`default_nettype wire

// ---- src/pcm_fifo.sv ----
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module pcm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_in, // System clock.
  input wire logic reset_in, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] wr_data_in, // Word to store.
  input wire logic wr_valid_in, // Writer offers a word.
  output logic wr_ready_out, // Room for a word.
  output logic [WIDTH-1:0] rd_data_out, // Oldest word.
  output logic rd_valid_out, // A word is waiting.
  input wire logic rd_ready_in // Reader takes the word.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count.
  assign wr_ready_out = (count != (AW+1)'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out = mem[rd_ptr];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  // Storage needs no reset; only the pointers and the fill count define what is valid.
  always_ff @(posedge core_clk_in)
  begin
    if (push)
      mem[wr_ptr] <= wr_data_in;
  end

  // Pointers wrap at DEPTH, which is a power of two.
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // pcm_fifo
`default_nettype wire
